// ---- verilog/switch_access_defines.svh ----
`ifndef SWITCH_ACCESS_DEFINES_SVH
`define SWITCH_ACCESS_DEFINES_SVH

// ****************************************************************
// Register word offsets (byte addresses)
// ****************************************************************
`define OFS_ADDR    8'h00
`define OFS_DATA    8'h04
`define OFS_CMD     8'h08
`define OFS_STATUS  8'h0C
`define OFS_SYNC_CTRL 8'h10
`define OFS_A_DATA  8'h14
`define OFS_B_DATA  8'h18
`define OFS_A_RX    8'h1C
`define OFS_B_RX    8'h20
`define OFS_A_TX    8'h24
`define OFS_B_TX    8'h28
`define OFS_MODE    8'h2C

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define BIT_DIR       7
`define BIT_RWS       7
`define BIT_BUSY      7
`define BIT_A_EN      6
`define BIT_B_EN      7
`define CMD_OP_CM_CODE 3'b011
`define CMD_CTRL_READ 8'h_F0
`define CMD_CM_DATA   4'h9
`define CMC_UP_ACCESS 4'h9
`define CMC_DCH_DEC   4'h8
`define CMC_DCH_CEN   4'hA
`define CMC_SIG8      4'hB
`define CMC_NONE      4'h0
`define CM_DEPTH      256
`define DM_DEPTH      256
`define BUSY_CYCLES   4'h3
`define BYTE_ZERO     8'h00
`define NIB_ZERO      4'h0

`endif

// ---- verilog/switch_access_pkg.sv ----
package switch_access_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEM,
      ST_SYNC
   } access_state_t;
endpackage : switch_access_pkg

// ---- verilog/switch_memory_access_sync_transfer.sv ----
// Operation
// - Downstream D-channel codes stored at even/odd addresses
// - Upstream D-channel codes stored at even/odd addresses
// - Downstream signaling uses 1010 even, 1011 odd
// - Upstream signaling 6-bit 1010, 8-bit 1011
// - Arbiter D-channel codes accepted like others
// - Code 1001 gives processor slot, stores idle
// - Processor slot swaps data field with line
// - Control-read returns code in low nibble
// - Address bit 7 picks upstream or downstream
// - Data memory address decodes per PCM mode
// - Control memory address decodes per CONFIGURABLE_SERIAL_PORT mode
// - Data register holds value read or written
// - Channel A buffer, bit 7 first
// - Channel B buffer, bit 7 first
// - Channel A receive bit 7 picks interface
// - Channel B receive address like channel A
// - Channel A transmit bit 7 picks interface
// - Channel B transmit address like channel A
// - Code write also stores data byte
// - Busy set during synchronous transfers too
// - Channel moves data only when enabled
`timescale 1ns/1ns
`default_nettype none
`include "switch_access_defines.svh"

module switch_memory_access_sync_transfer (
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        frame_start_i,
   input  wire logic        slot_strobe_i,
   input  wire logic        slot_is_cfi_i,
   input  wire logic        slot_upstream_i,
   input  wire logic [6:0]  slot_address_i,
   input  wire logic [7:0]  slot_rx_data_i,
   output logic      [7:0]  slot_tx_data_o,
   output logic             slot_tx_valid_o
);

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   // Normalise an address into {port, slot} so the serial side and the
   // processor side meet on the same index whatever the mode is.
   function automatic logic [6:0] pcm_index(input logic [1:0] mode,
                                            input logic [6:0] a);
      case (mode)
         2'd0:    pcm_index = {a[2:1], a[6:3], a[0]};
         2'd1,
         2'd3:    pcm_index = {a[2], a[6:3], a[1:0]};
         default: pcm_index = a;
      endcase
   endfunction : pcm_index

   function automatic logic [6:0] cfi_index(input logic [1:0] mode,
                                            input logic [6:0] a);
      case (mode)
         2'd0:    cfi_index = {a[2:1], a[6:3], a[0]};
         2'd1:    cfi_index = {a[1], a[6:2], a[0]};
         2'd3:    cfi_index = {a[3:1], a[6:4], a[0]};
         default: cfi_index = a;
      endcase
   endfunction : cfi_index

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] memory_address_reg_q;
   logic [7:0] memory_data_reg_q;
   logic [7:0] access_command_reg_q;
   logic [7:0] sync_ctrl_q;
   logic [7:0] sync_a_buffer_q;
   logic [7:0] sync_b_buffer_q;
   logic [7:0] sync_a_rx_addr_reg_q;
   logic [7:0] sync_b_rx_addr_reg_q;
   logic [7:0] sync_a_tx_addr_reg_q;
   logic [7:0] sync_b_tx_addr_reg_q;
   logic [7:0] mode_q;
   logic       memory_access_busy_q;
   logic [3:0] busy_cnt_q;
   logic       ack_q;
   logic [7:0] tx_data_q;
   logic       tx_valid_q;
   switch_access_pkg::access_state_t state_q;

   // Memories: index {direction, port/slot}
   logic [7:0] cm_data [`CM_DEPTH];
   logic [3:0] cm_code [`CM_DEPTH];
   logic [7:0] dm_data [`DM_DEPTH];

   logic       req;
   logic       wr;
   logic       cmd_wr;
   logic [1:0] pcm_mode;
   logic [1:0] cfi_mode;
   logic [7:0] cm_idx;
   logic [7:0] dm_idx;
   logic [7:0] ser_cm_idx;
   logic       sync_a_hit_rx;
   logic       sync_b_hit_rx;
   logic       sync_a_hit_tx;
   logic       sync_b_hit_tx;
   logic       up_slot;

   assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr       = req & wb_we_i & wb_sel_i[0];
   assign cmd_wr   = wr & (wb_adr_i == `OFS_CMD);
   assign pcm_mode = mode_q[1:0];
   assign cfi_mode = mode_q[3:2];

   assign cm_idx = {memory_address_reg_q[`BIT_DIR],
                    cfi_index(cfi_mode, memory_address_reg_q[6:0])};
   assign dm_idx = {memory_address_reg_q[`BIT_DIR],
                    pcm_index(pcm_mode, memory_address_reg_q[6:0])};
   assign ser_cm_idx = {slot_upstream_i,
                        cfi_index(cfi_mode, slot_address_i)};

   // Receive/transmit matches: bit 7 picks interface, low bits the slot
   function automatic logic slot_hit(input logic [7:0] r,
                                     input logic [1:0] pm,
                                     input logic [1:0] cm,
                                     input logic       configurable_serial_port,
                                     input logic [6:0] sa);
      if (r[7] != configurable_serial_port)
         slot_hit = 1'b0;
      else if (configurable_serial_port)
         slot_hit = cfi_index(cm, r[6:0]) == cfi_index(cm, sa);
      else
         slot_hit = pcm_index(pm, r[6:0]) == pcm_index(pm, sa);
   endfunction : slot_hit

   assign sync_a_hit_rx = slot_strobe_i & sync_ctrl_q[`BIT_A_EN] &
      slot_hit(sync_a_rx_addr_reg_q, pcm_mode, cfi_mode,
               slot_is_cfi_i, slot_address_i);
   assign sync_b_hit_rx = slot_strobe_i & sync_ctrl_q[`BIT_B_EN] &
      slot_hit(sync_b_rx_addr_reg_q, pcm_mode, cfi_mode,
               slot_is_cfi_i, slot_address_i);
   assign sync_a_hit_tx = slot_strobe_i & sync_ctrl_q[`BIT_A_EN] &
      slot_hit(sync_a_tx_addr_reg_q, pcm_mode, cfi_mode,
               slot_is_cfi_i, slot_address_i);
   assign sync_b_hit_tx = slot_strobe_i & sync_ctrl_q[`BIT_B_EN] &
      slot_hit(sync_b_tx_addr_reg_q, pcm_mode, cfi_mode,
               slot_is_cfi_i, slot_address_i);
   assign up_slot = slot_strobe_i & slot_is_cfi_i &
      (cm_code[ser_cm_idx] == `CMC_UP_ACCESS);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // Every access answers one cycle after the request; unmapped reads 0
   always_ff @(posedge clock_i) begin
      if (!reset_n_i)
         ack_q <= 1'b0;
      else
         ack_q <= req;
   end

   assign wb_ack_o = ack_q;

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         case (wb_adr_i)
            `OFS_ADDR:      wb_dat_o <= {24'h00_0000, memory_address_reg_q};
            `OFS_DATA:      wb_dat_o <= {24'h00_0000, memory_data_reg_q};
            `OFS_CMD:       wb_dat_o <= {24'h00_0000, access_command_reg_q};
            `OFS_STATUS:    wb_dat_o <= {24'h00_0000,
                                         memory_access_busy_q, 7'h00};
            `OFS_SYNC_CTRL: wb_dat_o <= {24'h00_0000, sync_ctrl_q};
            `OFS_A_DATA:    wb_dat_o <= {24'h00_0000, sync_a_buffer_q};
            `OFS_B_DATA:    wb_dat_o <= {24'h00_0000, sync_b_buffer_q};
            `OFS_A_RX:      wb_dat_o <= {24'h00_0000, sync_a_rx_addr_reg_q};
            `OFS_B_RX:      wb_dat_o <= {24'h00_0000, sync_b_rx_addr_reg_q};
            `OFS_A_TX:      wb_dat_o <= {24'h00_0000, sync_a_tx_addr_reg_q};
            `OFS_B_TX:      wb_dat_o <= {24'h00_0000, sync_b_tx_addr_reg_q};
            `OFS_MODE:      wb_dat_o <= {24'h00_0000, mode_q};
            default:        wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         memory_address_reg_q <= `BYTE_ZERO;
         access_command_reg_q <= `BYTE_ZERO;
         sync_ctrl_q          <= `BYTE_ZERO;
         sync_a_rx_addr_reg_q <= `BYTE_ZERO;
         sync_b_rx_addr_reg_q <= `BYTE_ZERO;
         sync_a_tx_addr_reg_q <= `BYTE_ZERO;
         sync_b_tx_addr_reg_q <= `BYTE_ZERO;
         mode_q               <= `BYTE_ZERO;
      end else if (wr) begin
         case (wb_adr_i)
            `OFS_ADDR:      memory_address_reg_q <= wb_dat_i[7:0];
            `OFS_CMD:       access_command_reg_q <= wb_dat_i[7:0];
            `OFS_SYNC_CTRL: sync_ctrl_q          <= wb_dat_i[7:0];
            `OFS_A_RX:      sync_a_rx_addr_reg_q <= wb_dat_i[7:0];
            `OFS_B_RX:      sync_b_rx_addr_reg_q <= wb_dat_i[7:0];
            `OFS_A_TX:      sync_a_tx_addr_reg_q <= wb_dat_i[7:0];
            `OFS_B_TX:      sync_b_tx_addr_reg_q <= wb_dat_i[7:0];
            `OFS_MODE:      mode_q               <= wb_dat_i[7:0];
            default:        ;
         endcase
      end
   end

   // ****************************************************************
   // Memory access engine
   // ****************************************************************
   // A command write made while idle starts the access; it completes after a short
   // fixed busy window so software sees busy and must poll for it.
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state_q              <= switch_access_pkg::ST_IDLE;
         busy_cnt_q           <= `NIB_ZERO;
         memory_access_busy_q <= 1'b0;
      end else begin
         case (state_q)
            switch_access_pkg::ST_IDLE: begin
               if (cmd_wr) begin
                  state_q              <= switch_access_pkg::ST_MEM;
                  busy_cnt_q           <= `BUSY_CYCLES;
                  memory_access_busy_q <= 1'b1;
               end else if (sync_a_hit_rx | sync_b_hit_rx |
                            sync_a_hit_tx | sync_b_hit_tx) begin
                  state_q              <= switch_access_pkg::ST_SYNC;
                  memory_access_busy_q <= 1'b1;
               end
            end
            switch_access_pkg::ST_MEM: begin
               if (busy_cnt_q == `NIB_ZERO) begin
                  state_q              <= switch_access_pkg::ST_IDLE;
                  memory_access_busy_q <= 1'b0;
               end else begin
                  busy_cnt_q <= busy_cnt_q - 4'h1;
               end
            end
            switch_access_pkg::ST_SYNC: begin
               state_q              <= switch_access_pkg::ST_IDLE;
               memory_access_busy_q <= 1'b0;
            end
            default: begin
               state_q              <= switch_access_pkg::ST_IDLE;
               memory_access_busy_q <= 1'b0;
            end
         endcase
      end
   end

   // Memory data register: host writes, and read results of commands
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         memory_data_reg_q <= `BYTE_ZERO;
      end else if (wr && wb_adr_i == `OFS_DATA) begin
         memory_data_reg_q <= wb_dat_i[7:0];
      end else if (state_q == switch_access_pkg::ST_MEM &&
                   busy_cnt_q == `BUSY_CYCLES) begin
         if (access_command_reg_q == `CMD_CTRL_READ)
            memory_data_reg_q <= {4'h0, cm_code[cm_idx]};
         else if (access_command_reg_q[`BIT_RWS] &&
                  access_command_reg_q[6:3] == `CMD_CM_DATA)
            memory_data_reg_q <= cm_data[cm_idx];
         else if (access_command_reg_q[`BIT_RWS])
            memory_data_reg_q <= dm_data[dm_idx];
      end
   end

   // Control memory: code writes store data too; processor slots swap
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < `CM_DEPTH; i++) begin
            cm_code[i] <= `CMC_NONE;
            cm_data[i] <= `BYTE_ZERO;
         end
      end else if (state_q == switch_access_pkg::ST_MEM &&
                   busy_cnt_q == `BUSY_CYCLES &&
                   !access_command_reg_q[`BIT_RWS]) begin
         if (access_command_reg_q[6:4] == `CMD_OP_CM_CODE) begin
            // Any code incl. D-channel, signaling and arbiter pairs
            cm_code[cm_idx] <= access_command_reg_q[3:0];
            cm_data[cm_idx] <= memory_data_reg_q;
         end else if (access_command_reg_q[6:3] == `CMD_CM_DATA) begin
            cm_data[cm_idx] <= memory_data_reg_q;
         end
      end else if (up_slot && !slot_upstream_i) begin
         // Downstream slots are captured, as for the sync channels
         cm_data[ser_cm_idx] <= slot_rx_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < `DM_DEPTH; i++)
            dm_data[i] <= `BYTE_ZERO;
      end else if (state_q == switch_access_pkg::ST_MEM &&
                   busy_cnt_q == `BUSY_CYCLES &&
                   !access_command_reg_q[`BIT_RWS] &&
                   access_command_reg_q[6] == 1'b0 &&
                   access_command_reg_q[2:0] == 3'b000) begin
         dm_data[dm_idx] <= memory_data_reg_q;
      end
   end

   // ****************************************************************
   // Synchronous transfer channels
   // ****************************************************************
   // Buffers keep bit 7 as the first bit on the line; the serial side
   // delivers a whole slot byte in that order, once per frame slot.
   always_ff @(posedge clock_i) begin
      if (!reset_n_i)
         sync_a_buffer_q <= `BYTE_ZERO;
      else if (wr && wb_adr_i == `OFS_A_DATA)
         sync_a_buffer_q <= wb_dat_i[7:0];
      else if (sync_a_hit_rx && !slot_upstream_i)
         sync_a_buffer_q <= slot_rx_data_i;
   end

   always_ff @(posedge clock_i) begin
      if (!reset_n_i)
         sync_b_buffer_q <= `BYTE_ZERO;
      else if (wr && wb_adr_i == `OFS_B_DATA)
         sync_b_buffer_q <= wb_dat_i[7:0];
      else if (sync_b_hit_rx && !slot_upstream_i)
         sync_b_buffer_q <= slot_rx_data_i;
   end

   // Transmit: channel A wins over B if both target one slot
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         tx_data_q  <= `BYTE_ZERO;
         tx_valid_q <= 1'b0;
      end else if (frame_start_i) begin
         tx_valid_q <= 1'b0;
      end else if (sync_a_hit_tx && slot_upstream_i) begin
         tx_data_q  <= sync_a_buffer_q;
         tx_valid_q <= 1'b1;
      end else if (sync_b_hit_tx && slot_upstream_i) begin
         tx_data_q  <= sync_b_buffer_q;
         tx_valid_q <= 1'b1;
      end else if (up_slot && slot_upstream_i) begin
         tx_data_q  <= cm_data[ser_cm_idx];
         tx_valid_q <= 1'b1;
      end else begin
         tx_valid_q <= 1'b0;
      end
   end

   assign slot_tx_data_o  = tx_data_q;
   assign slot_tx_valid_o = tx_valid_q;

endmodule : switch_memory_access_sync_transfer
`default_nettype wire

// ---- bench/switch_access_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "switch_access_defines.svh"

module switch_access_checker (
   input wire logic        clock_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        frame_start_i,
   input wire logic        slot_strobe_i,
   input wire logic        slot_is_cfi_i,
   input wire logic        slot_upstream_i,
   input wire logic [6:0]  slot_address_i,
   input wire logic [7:0]  slot_rx_data_i,
   input wire logic [7:0]  slot_tx_data_o,
   input wire logic        slot_tx_valid_o
);
   logic take;
   logic en_q;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Mirror of the enable bits, so a send with both channels off shows up
   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         en_q <= 1'b0;
      end else if (take && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == `OFS_SYNC_CTRL) begin
         en_q <= wb_dat_i[`BIT_A_EN] | wb_dat_i[`BIT_B_EN];
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   property p_take_ack; take |=> wb_ack_o; endproperty
   a_take_ack: assert property (p_take_ack) else $error("no ack");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_upper_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits");
   property p_unmapped;
      take && !wb_we_i && wb_adr_i > `OFS_MODE |=> wb_dat_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_tx_cause;
      slot_tx_valid_o |-> $past(slot_strobe_i && slot_upstream_i);
   endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("stray send");
   property p_frame_clear;
      frame_start_i && !slot_strobe_i |=> !slot_tx_valid_o;
   endproperty
   a_frame_clear: assert property (p_frame_clear) else $error("frame");
   property p_tx_enable; slot_tx_valid_o |-> $past(en_q); endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("disabled send");

   c_write: cover property (take && wb_we_i);
   c_send: cover property (slot_tx_valid_o);
   c_unmapped: cover property (take && !wb_we_i && wb_adr_i > `OFS_MODE);
endmodule : switch_access_checker

bind switch_memory_access_sync_transfer switch_access_checker u_chk (
   .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .frame_start_i(frame_start_i),
   .slot_strobe_i(slot_strobe_i), .slot_is_cfi_i(slot_is_cfi_i),
   .slot_upstream_i(slot_upstream_i), .slot_address_i(slot_address_i),
   .slot_rx_data_i(slot_rx_data_i), .slot_tx_data_o(slot_tx_data_o),
   .slot_tx_valid_o(slot_tx_valid_o));
`default_nettype wire

// ---- bench/serial_line_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module serial_line_model (
   input  wire logic       clock_i,
   output logic            frame_start_o,
   output logic            strobe_o,
   output logic            is_cfi_o,
   output logic            upstream_o,
   output logic [6:0]      address_o,
   output logic [7:0]      rx_data_o,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_valid_i
);
   initial begin
      frame_start_o = 1'b0;
      strobe_o = 1'b0;
      is_cfi_o = 1'b0;
      upstream_o = 1'b0;
      address_o = 7'h00;
      rx_data_o = 8'h00;
   end
   // One slot per frame, so each hit also shows the per-frame pacing
   task automatic slot(input logic configurable_serial_port, input logic up, input logic [6:0] adr,
                       input logic [7:0] dat, output logic hit,
                       output logic [7:0] q);
      @(posedge clock_i);
      frame_start_o <= 1'b1;
      @(posedge clock_i);
      frame_start_o <= 1'b0;
      strobe_o <= 1'b1;
      is_cfi_o <= configurable_serial_port;
      upstream_o <= up;
      address_o <= adr;
      rx_data_o <= dat;
      @(posedge clock_i);
      strobe_o <= 1'b0;
      // Released lines carry junk so a late capture cannot look right
      address_o <= ~adr;
      rx_data_o <= ~dat;
      #1;
      hit = tx_valid_i;
      q = tx_data_i;
   endtask : slot
endmodule : serial_line_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "switch_access_defines.svh"

module tb_top;
   logic        clock_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        frame_start_i, slot_strobe_i, slot_is_cfi_i, slot_upstream_i;
   logic [6:0]  slot_address_i;
   logic [7:0]  slot_rx_data_i, slot_tx_data_o;
   logic        slot_tx_valid_o;
   int          num_errors = 0;
   int          tests_run = 0;
   logic [31:0] seed = 32'hdee8_2c59;
   int          mdl_code [int];
   int          mdl_data [int];

   switch_memory_access_sync_transfer DUT (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .frame_start_i(frame_start_i),
      .slot_strobe_i(slot_strobe_i), .slot_is_cfi_i(slot_is_cfi_i),
      .slot_upstream_i(slot_upstream_i), .slot_address_i(slot_address_i),
      .slot_rx_data_i(slot_rx_data_i), .slot_tx_data_o(slot_tx_data_o),
      .slot_tx_valid_o(slot_tx_valid_o));
   serial_line_model line (
      .clock_i(clock_i), .frame_start_o(frame_start_i),
      .strobe_o(slot_strobe_i), .is_cfi_o(slot_is_cfi_i),
      .upstream_o(slot_upstream_i), .address_o(slot_address_i),
      .rx_data_o(slot_rx_data_i), .tx_data_i(slot_tx_data_o),
      .tx_valid_i(slot_tx_valid_o));

   always #25 clock_i = ~clock_i;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction : rnd
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [7:0] dat, input logic [3:0] sel,
                     output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= {24'h00_0000, dat};
      do begin
         @(posedge clock_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) num_errors++;
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      logic [31:0] unused;
      wb(1'b1, adr, dat, 4'hF, unused);
   endtask : wr
   task automatic rd(input logic [7:0] adr, output logic [31:0] rdat);
      wb(1'b0, adr, 8'h00, 4'hF, rdat);
   endtask : rd
   task automatic mem_cmd(input logic [7:0] adr, input logic [7:0] dat,
                          input logic [7:0] cmd);
      logic [31:0] s;
      int n;
      n = 0;
      wr(`OFS_ADDR, adr);
      wr(`OFS_DATA, dat);
      wr(`OFS_CMD, cmd);
      do begin
         rd(`OFS_STATUS, s);
         n++;
      end while (s[`BIT_BUSY] !== 1'b0 && n < 20);
      if (s[`BIT_BUSY] !== 1'b0) num_errors++;
   endtask : mem_cmd

   initial begin : watchdog
      #(50 * 20000);
      num_errors++;
      results();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin : main
      logic [31:0] r;
      logic [7:0]  v, tx_a, tx_b, a;
      logic [2:0]  kk;
      logic        hit;
      logic [7:0]  q;
      logic [7:0]  ofs [8] = '{`OFS_ADDR, `OFS_DATA, `OFS_A_DATA,
         `OFS_B_DATA, `OFS_A_RX, `OFS_B_RX, `OFS_A_TX, `OFS_B_TX};
      logic [3:0]  codes [8] = '{4'hA, 4'h8, 4'hB, 4'h0, 4'hA, 4'hB, 4'h8,
                                 4'h9};
      repeat (4) @(posedge clock_i);
      reset_n_i <= 1'b1;
      foreach (ofs[i]) begin
         v = rnd();
         wr(ofs[i], v);
         rd(ofs[i], r);
         check("readback", r, {24'h00_0000, v});
      end
      wr(`OFS_A_DATA, 8'h5A);
      wb(1'b1, `OFS_A_DATA, 8'hA5, 4'hE, r);
      rd(`OFS_A_DATA, r);
      check("sel_ignored", r, 32'h0000_005A);
      rd(8'h30, r);
      check("unmapped", r, 32'h0000_0000);
      // Pairs differ only in the direction bit, so both blocks must hold
      for (int k = 0; k < 8; k++) begin
         kk = 3'(k);
         a = {kk[0], 4'h5, kk[2:1], kk[1]};
         v = rnd();
         mdl_code[k] = codes[k];
         mdl_data[k] = v;
         mem_cmd(a, v, {4'h3, codes[k]});
      end
      for (int k = 0; k < 8; k++) begin
         kk = 3'(k);
         a = {kk[0], 4'h5, kk[2:1], kk[1]};
         mem_cmd(a, 8'h00, `CMD_CTRL_READ);
         rd(`OFS_DATA, r);
         check("cm_code", 32'(r[3:0]), mdl_code[k]);
         mem_cmd(a, 8'h00, 8'hC8);
         rd(`OFS_DATA, r);
         check("cm_data", r, mdl_data[k]);
      end
      wr(`OFS_SYNC_CTRL, 8'hC0);
      wr(`OFS_A_RX, 8'h95);
      wr(`OFS_B_RX, 8'h22);
      v = rnd();
      line.slot(1'b1, 1'b0, 7'h15, v, hit, q);
      rd(`OFS_A_DATA, r);
      check("a_rx", r, {24'h00_0000, v});
      line.slot(1'b0, 1'b0, 7'h15, ~v, hit, q);
      rd(`OFS_A_DATA, r);
      check("a_rx_iface", r, {24'h00_0000, v});
      v = rnd();
      line.slot(1'b0, 1'b0, 7'h22, v, hit, q);
      rd(`OFS_B_DATA, r);
      check("b_rx", r, {24'h00_0000, v});
      tx_a = rnd();
      tx_b = rnd();
      wr(`OFS_A_DATA, tx_a);
      wr(`OFS_A_TX, 8'h05);
      wr(`OFS_B_DATA, tx_b);
      wr(`OFS_B_TX, 8'hB3);
      line.slot(1'b0, 1'b1, 7'h05, rnd(), hit, q);
      check("a_tx", {hit, q}, {1'b1, tx_a});
      line.slot(1'b1, 1'b1, 7'h33, rnd(), hit, q);
      check("b_tx", {hit, q}, {1'b1, tx_b});
      // Processor-owned upstream slot sends the stored idle byte
      v = rnd();
      mem_cmd(8'hC4, v, 8'h39);
      line.slot(1'b1, 1'b1, 7'h44, rnd(), hit, q);
      check("cpu_tx", {hit, q}, {1'b1, v});
      line.slot(1'b1, 1'b1, 7'h05, rnd(), hit, q);
      check("a_tx_iface", 32'(hit), 32'h0000_0000);
      wr(`OFS_SYNC_CTRL, 8'h00);
      line.slot(1'b1, 1'b0, 7'h15, ~tx_a, hit, q);
      rd(`OFS_A_DATA, r);
      check("a_off_rx", r, {24'h00_0000, tx_a});
      line.slot(1'b0, 1'b1, 7'h05, rnd(), hit, q);
      check("a_off_tx", 32'(hit), 32'h0000_0000);
      results();
   end
endmodule : tb_top
`default_nettype wire
